// ### logic/spi_cfg_defines.svh
// offsets, field positions, reset values and counts of the configuration serial port
`ifndef SPI_CFG_DEFINES_SVH
`define SPI_CFG_DEFINES_SVH
`define INSTR_LAST 5'h0f
`define BYTE_LAST 5'h07
`define ADDR_CFG 15'h0000
`define ADDR_TW_LO 15'h0001
`define ADDR_TW_HI 15'h0002
`define ADDR_TW_LOAD 15'h0003
`define CFG_SOFT_M 7
`define CFG_LSB 6
`define CFG_ASC 5
`define CFG_FOUR 4
`define CFG_FOUR_M 3
`define CFG_ASC_M 2
`define CFG_LSB_M 1
`define CFG_SOFT 0
`define CFG_RESET 8'h00
`define H_CTRL 10'h000
`define H_ADDR 10'h001
`define H_WDATA 10'h002
`define H_RDATA 10'h003
`define H_STATUS 10'h004
`define CTRL_GO 0
`define CTRL_READ 1
`define CTRL_LSB 2
`define CTRL_FOUR 3
`define ST_BUSY 0
`define ST_DONE 1
`define SCLK_HALF 8'h04
`define WARM_FALLS 4'h8
`endif

// ### logic/spi_cfg_pkg.sv
// types shared by both ends of the configuration serial port
package spi_cfg_pkg;
    typedef enum logic {PH_INSTR, PH_DATA} dev_phase_t;
    typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} host_state_t;
endpackage

// ### logic/spi_cfg_if.sv
// serial link between the host controller and the configuration port
`timescale 1ns/1ps
interface spi_cfg_if;
    logic sclk;
    logic cs_n;
    logic host_sdio_o;
    logic host_sdio_oe;
    logic dev_sdio_o;
    logic dev_sdio_oe;
    logic sep_out_o;
    logic sep_out_oe;
    logic sdio;
    logic separate_output_pin;
    // resolved pin levels, pulled high when nobody drives
    assign sdio = dev_sdio_oe ? dev_sdio_o : (host_sdio_oe ? host_sdio_o : 1'b1);
    assign separate_output_pin = sep_out_oe ? sep_out_o : 1'b1;
    modport device(input sclk, input cs_n, input sdio, output dev_sdio_o, output dev_sdio_oe,
                   output sep_out_o, output sep_out_oe);
    modport host(output sclk, output cs_n, output host_sdio_o, output host_sdio_oe,
                 input sdio, input separate_output_pin);
endinterface

// ### logic/sync2.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ps
module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_d,
    output logic [WIDTH-1:0] o_q
);
    logic [WIDTH-1:0] meta_q;

    // first stage is read only by the second
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            meta_q <= '0;
            o_q <= '0;
        end else begin
            meta_q <= i_d;
            o_q <= meta_q;
        end
    end
endmodule // sync2

// ### logic/spi_cfg_device.sv
// configuration serial port: the device end, clocked by the serial clock
// Function
// - sample on rising, launch on falling edge
// - data pin released while select high
// - host keeps select low whole cycle
// - wiring bits pick four-wire or three-wire
// - mirrored bit-order bits, default MSB first
// - MSB first: direction, address, data
// - LSB first: address, direction, data
// - each further byte steps the address
// - mirrored ascend bits: increment or decrement
// - select high then low restarts
// - config write checks first nibble only
// - soft reset acts after full byte
// - first sixteen rising edges are instruction
// - top instruction bit 1 means read
// - byte commits at last bit; tuning word on load
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`include "spi_cfg_defines.svh"
module spi_cfg_device
    import spi_cfg_pkg::*;
(
    // serial link
    spi_cfg_if.device LINK,
    // system side
    input wire logic I_CLK,
    input wire logic I_RST,
    output logic [15:0] O_TUNING_WORD,
    output logic O_TUNING_LOAD,
    output logic O_SOFT_RESET
);
    // frame state, cleared by select high
    dev_phase_t phase_q, phase_d;
    logic [4:0] cnt_q, cnt_d;
    logic [15:0] sr_q, sr_d;
    logic read_q, read_d;
    logic [14:0] addr_q, addr_d;
    logic wr_fire;
    logic [7:0] wr_byte;
    // register state, cleared by reset; soft reset clears cfg_q, tw_lo_q and tw_hi_q only
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] tw_lo_q, tw_lo_d;
    logic [7:0] tw_hi_q, tw_hi_d;
    logic [15:0] tw_act_q, tw_act_d;
    logic load_tgl_q, load_tgl_d;
    logic soft_tgl_q, soft_tgl_d;
    logic [7:0] rbyte;
    logic lsb;
    logic four;
    logic ascend;
    // output launch state
    logic out_q, out_d;
    logic oe_q, oe_d;
    // reset crossing and system-side state
    logic rst_hold_q, rst_hold_d;
    logic rst_meta_q;
    logic rst_s;
    logic [2:0] back_s;
    logic [1:0] seen_q, seen_d;
    logic [15:0] tw_out_q, tw_out_d;
    logic load_p_q, load_p_d;
    logic soft_p_q, soft_p_d;

    assign lsb = cfg_q[`CFG_LSB];
    assign four = cfg_q[`CFG_FOUR];
    assign ascend = cfg_q[`CFG_ASC];

    // reset enters at once, leaves on the second serial rise: the serial clock stands still in reset
    always_ff @(posedge LINK.sclk or posedge rst_hold_q) begin
        if (rst_hold_q) begin
            rst_meta_q <= 1'b1;
            rst_s <= 1'b1;
        end else begin
            rst_meta_q <= 1'b0;
            rst_s <= rst_meta_q;
        end
    end

    // shift in one bit per rising edge; the byte layout is the same for both orders
    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q + 5'h01;
        read_d = read_q;
        addr_d = addr_q;
        wr_fire = 1'b0;
        wr_byte = 8'h00;
        if (phase_q == PH_INSTR) begin
            sr_d = lsb ? {LINK.sdio, sr_q[15:1]} : {sr_q[14:0], LINK.sdio};
            if (cnt_q == `INSTR_LAST) begin
                phase_d = PH_DATA;
                cnt_d = 5'h00;
                read_d = sr_d[15];
                addr_d = sr_d[14:0];
            end
        end else begin
            sr_d = {8'h00, lsb ? {LINK.sdio, sr_q[7:1]} : {sr_q[6:0], LINK.sdio}};
            if (cnt_q == `BYTE_LAST) begin
                cnt_d = 5'h00;
                wr_fire = ~read_q;
                wr_byte = sr_d[7:0];
                addr_d = ascend ? addr_q + 15'h0001 : addr_q - 15'h0001;
            end
        end
    end

    // select high returns the port to the instruction phase
    always_ff @(posedge LINK.sclk or posedge LINK.cs_n) begin
        if (LINK.cs_n) begin
            phase_q <= PH_INSTR;
            cnt_q <= 5'h00;
            sr_q <= 16'h0000;
            read_q <= 1'b0;
            addr_q <= 15'h0000;
        end else begin
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            sr_q <= sr_d;
            read_q <= read_d;
            addr_q <= addr_d;
        end
    end

    // byte commit; config writes look only at the first nibble received
    always_comb begin
        cfg_d = cfg_q;
        tw_lo_d = tw_lo_q;
        tw_hi_d = tw_hi_q;
        tw_act_d = tw_act_q;
        load_tgl_d = load_tgl_q;
        soft_tgl_d = soft_tgl_q;
        if (wr_fire) begin
            case (addr_q)
                `ADDR_CFG: begin
                    // first nibble is bits 7..4 in MSB order, bits 0..3 in LSB order
                    if (lsb ? wr_byte[`CFG_SOFT] : wr_byte[`CFG_SOFT_M]) begin
                        cfg_d = `CFG_RESET;
                        tw_lo_d = 8'h00;
                        tw_hi_d = 8'h00;
                        soft_tgl_d = ~soft_tgl_q;
                    end else begin
                        cfg_d = `CFG_RESET;
                        cfg_d[`CFG_LSB] = lsb ? wr_byte[`CFG_LSB_M] : wr_byte[`CFG_LSB];
                        cfg_d[`CFG_ASC] = lsb ? wr_byte[`CFG_ASC_M] : wr_byte[`CFG_ASC];
                        cfg_d[`CFG_FOUR] = lsb ? wr_byte[`CFG_FOUR_M] : wr_byte[`CFG_FOUR];
                        cfg_d[`CFG_LSB_M] = cfg_d[`CFG_LSB];
                        cfg_d[`CFG_ASC_M] = cfg_d[`CFG_ASC];
                        cfg_d[`CFG_FOUR_M] = cfg_d[`CFG_FOUR];
                    end
                end
                `ADDR_TW_LO: tw_lo_d = wr_byte;
                `ADDR_TW_HI: tw_hi_d = wr_byte;
                `ADDR_TW_LOAD: begin
                    // the live tuning word changes only on a load request
                    if (wr_byte[0]) begin
                        tw_act_d = {tw_hi_q, tw_lo_q};
                        load_tgl_d = ~load_tgl_q;
                    end
                end
                default: cfg_d = cfg_q;
            endcase
        end
    end

    // register state survives frames; toggles stay put between events
    always_ff @(posedge LINK.sclk) begin
        if (rst_s) begin
            cfg_q <= `CFG_RESET;
            tw_lo_q <= 8'h00;
            tw_hi_q <= 8'h00;
            tw_act_q <= 16'h0000;
            load_tgl_q <= 1'b0;
            soft_tgl_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            tw_lo_q <= tw_lo_d;
            tw_hi_q <= tw_hi_d;
            tw_act_q <= tw_act_d;
            load_tgl_q <= load_tgl_d;
            soft_tgl_q <= soft_tgl_d;
        end
    end

    // read mux; the load request reads back as zero since it does not hold
    always_comb begin
        case (addr_q)
            `ADDR_CFG: rbyte = cfg_q;
            `ADDR_TW_LO: rbyte = tw_lo_q;
            `ADDR_TW_HI: rbyte = tw_hi_q;
            default: rbyte = 8'h00;
        endcase
    end

    // launch bit cnt of the addressed byte; instruction phase never drives
    always_comb begin
        out_d = lsb ? rbyte[cnt_q[2:0]] : rbyte[3'h7 - cnt_q[2:0]];
        oe_d = (phase_q == PH_DATA) && read_q;
    end

    always_ff @(negedge LINK.sclk or posedge LINK.cs_n) begin
        if (LINK.cs_n) begin
            out_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            out_q <= out_d;
            oe_q <= oe_d;
        end
    end

    // select high releases the pins at once, without waiting for an edge
    assign LINK.dev_sdio_o = out_q;
    assign LINK.dev_sdio_oe = oe_q & ~four & ~LINK.cs_n;
    assign LINK.sep_out_o = out_q;
    assign LINK.sep_out_oe = oe_q & four & ~LINK.cs_n;

    // events and reset acknowledge carried back into the system clock
    sync2 #(.WIDTH(3)) u_back_sync (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_d({rst_s, soft_tgl_q, load_tgl_q}),
        .o_q(back_s)
    );

    // hold the reset request until the serial side has seen it;
    // the serial clock may stand still, so a short pulse alone could be missed
    always_comb begin
        rst_hold_d = back_s[2] ? 1'b0 : rst_hold_q;
        seen_d = back_s[1:0];
        load_p_d = (back_s[0] ^ seen_q[0]) & ~rst_hold_q & ~back_s[2]; // toggles unknown until serial reset
        soft_p_d = (back_s[1] ^ seen_q[1]) & ~rst_hold_q & ~back_s[2];
        tw_out_d = load_p_d ? tw_act_q : tw_out_q;
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rst_hold_q <= 1'b1;
            seen_q <= 2'b00;
            load_p_q <= 1'b0;
            soft_p_q <= 1'b0;
            tw_out_q <= 16'h0000;
        end else begin
            rst_hold_q <= rst_hold_d;
            seen_q <= seen_d;
            load_p_q <= load_p_d;
            soft_p_q <= soft_p_d;
            tw_out_q <= tw_out_d; // word is stable by the time its toggle arrives
        end
    end

    assign O_TUNING_WORD = tw_out_q;
    assign O_TUNING_LOAD = load_p_q;
    assign O_SOFT_RESET = soft_p_q;
endmodule // spi_cfg_device

// ### logic/spi_cfg_host.sv
// configuration serial port: the host controller end, with an APB register slave
`timescale 1ns/1ps
`include "spi_cfg_defines.svh"
module spi_cfg_host
    import spi_cfg_pkg::*;
#(
    parameter logic [7:0] SCLK_HALF = `SCLK_HALF
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // serial link
    spi_cfg_if.host LINK
);
    host_state_t state_q, state_d;
    logic [7:0] div_q, div_d;
    logic sclk_q, sclk_d;
    logic cs_n_q, cs_n_d;
    logic tx_q, tx_d;
    logic oe_q, oe_d;
    logic [5:0] bit_q, bit_d;
    logic [3:0] gap_q, gap_d;
    logic go_q, go_d;
    logic done_q, done_d;
    logic [5:0] ctrl_q, ctrl_d;
    logic [14:0] addr_q, addr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] prdata_q, prdata_d;
    logic [1:0] sdi_s;
    logic tick, rise, fall, wr, mapped;
    logic [5:0] nidx, last, didx;
    logic [15:0] instr;

    // both possible input pins pass two flops
    sync2 #(.WIDTH(2)) u_sdi_sync (
        .i_clk(I_CLK),
        .i_rst(I_RST),
        .i_d({LINK.separate_output_pin, LINK.sdio}),
        .o_q(sdi_s)
    );

    assign tick = div_q == SCLK_HALF - 8'h01;
    assign rise = tick & ~sclk_q;
    assign fall = tick & sclk_q;
    assign wr = I_PSEL & I_PENABLE & I_PWRITE;
    assign mapped = I_PADDR[11:2] <= `H_STATUS;
    // ctrl[5:4] holds bytes minus one, so a burst is one to four bytes
    assign last = 6'd23 + {1'b0, ctrl_q[5:4], 3'b000};
    assign nidx = (state_q == H_RUN) ? bit_q + 6'h01 : 6'h00;
    assign didx = nidx - 6'd16;
    assign instr = ctrl_q[`CTRL_LSB] ? {addr_q[0], addr_q[1], addr_q[2], addr_q[3], addr_q[4], addr_q[5],
        addr_q[6], addr_q[7], addr_q[8], addr_q[9], addr_q[10], addr_q[11], addr_q[12], addr_q[13],
        addr_q[14], ctrl_q[`CTRL_READ]} : {ctrl_q[`CTRL_READ], addr_q};

    // free-running clock divider; data changes on falls, input is taken on rises
    always_comb begin
        div_d = tick ? 8'h00 : div_q + 8'h01;
        sclk_d = tick ? ~sclk_q : sclk_q;
        state_d = state_q;
        cs_n_d = cs_n_q;
        tx_d = tx_q;
        oe_d = oe_q;
        bit_d = bit_q;
        gap_d = gap_q;
        go_d = go_q;
        rdata_d = rdata_q;
        case (state_q)
            H_IDLE: begin
                if (fall && go_q) begin
                    state_d = H_RUN;
                    cs_n_d = 1'b0;
                    bit_d = 6'h00;
                    go_d = 1'b0;
                    oe_d = 1'b1;
                    tx_d = instr[15];
                    rdata_d = 32'h0000_0000;
                end
            end
            H_RUN: begin
                if (rise && ctrl_q[`CTRL_READ] && bit_q >= 6'd16) begin
                    rdata_d[{bit_q[4:3] - 2'b10, ctrl_q[`CTRL_LSB] ? bit_q[2:0] : 3'h7 - bit_q[2:0]}] =
                        ctrl_q[`CTRL_FOUR] ? sdi_s[1] : sdi_s[0];
                end
                if (fall) begin
                    if (bit_q == last) begin
                        state_d = H_GAP;
                        cs_n_d = 1'b1;
                        oe_d = 1'b0;
                        gap_d = 4'h1;
                    end else begin
                        bit_d = nidx;
                        // release the shared pin while the device answers
                        oe_d = ~(ctrl_q[`CTRL_READ] && nidx >= 6'd16 && !ctrl_q[`CTRL_FOUR]);
                        if (nidx < 6'd16) begin
                            tx_d = instr[4'hf - nidx[3:0]];
                        end else begin
                            tx_d = wdata_q[{didx[4:3], ctrl_q[`CTRL_LSB] ? didx[2:0] : 3'h7 - didx[2:0]}];
                        end
                    end
                end
            end
            H_GAP: begin
                // select stays high at least one full clock between frames
                if (fall) begin
                    gap_d = gap_q - 4'h1;
                    if (gap_q == 4'h1) begin
                        state_d = H_IDLE;
                    end
                end
            end
            default: state_d = H_IDLE;
        endcase
        ctrl_d = ctrl_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        // writes are refused while a transfer is pending or running
        if (wr && state_q == H_IDLE && !go_q) begin
            case (I_PADDR[11:2])
                `H_CTRL: begin
                    ctrl_d = I_PWDATA[5:0];
                    go_d = I_PWDATA[`CTRL_GO];
                end
                `H_ADDR: addr_d = I_PWDATA[14:0];
                `H_WDATA: wdata_d = I_PWDATA;
                default: ctrl_d = ctrl_q;
            endcase
        end
        // completion sets over a simultaneous write-one clear
        done_d = (state_q == H_RUN && fall && bit_q == last) ? 1'b1 :
            (wr && I_PADDR[11:2] == `H_STATUS && I_PWDATA[`ST_DONE]) ? 1'b0 : done_q;
        prdata_d = prdata_q;
        if (I_PSEL && !I_PENABLE && !I_PWRITE) begin
            case (I_PADDR[11:2])
                `H_CTRL: prdata_d = {26'h0, ctrl_q[5:1], go_q};
                `H_ADDR: prdata_d = {17'h0, addr_q};
                `H_WDATA: prdata_d = wdata_q;
                `H_RDATA: prdata_d = rdata_q;
                `H_STATUS: prdata_d = {30'h0, done_q, state_q != H_IDLE || go_q};
                default: prdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            state_q <= H_GAP;
            gap_q <= `WARM_FALLS; // lets the device finish its own reset first
            div_q <= 8'h00;
            sclk_q <= 1'b0;
            cs_n_q <= 1'b1;
            tx_q <= 1'b0;
            oe_q <= 1'b0;
            bit_q <= 6'h00;
            go_q <= 1'b0;
            done_q <= 1'b0;
            ctrl_q <= 6'h00;
            addr_q <= 15'h0000;
            wdata_q <= 32'h0000_0000;
            rdata_q <= 32'h0000_0000;
            prdata_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            gap_q <= gap_d;
            div_q <= div_d;
            sclk_q <= sclk_d;
            cs_n_q <= cs_n_d;
            tx_q <= tx_d;
            oe_q <= oe_d;
            bit_q <= bit_d;
            go_q <= go_d;
            done_q <= done_d;
            ctrl_q <= ctrl_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            rdata_q <= rdata_d;
            prdata_q <= prdata_d;
        end
    end

    assign LINK.sclk = sclk_q;
    assign LINK.cs_n = cs_n_q;
    assign LINK.host_sdio_o = tx_q;
    assign LINK.host_sdio_oe = oe_q;
    assign O_PRDATA = prdata_q;
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;
endmodule // spi_cfg_host

// ### sim/spi_cfg_chk.sv
// concurrent checks on the serial link between the host and device ends
`timescale 1ns/1ps
module spi_cfg_chk (
    // system clock and reset
    input wire logic I_CLK,
    input wire logic I_RST,
    // link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_o,
    input wire logic dev_sdio_oe,
    input wire logic sep_out_o,
    input wire logic sep_out_oe
);
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    logic [7:0] rise_q;
    logic [7:0] rise_d;
    logic sclk_q;
    // rising serial edges within a frame; saturates so a runaway frame cannot wrap into a legal count
    always_comb begin
        rise_d = cs_n ? 8'h00 : ((sclk && !sclk_q && rise_q != 8'hff) ? rise_q + 8'h01 : rise_q);
    end
    // register the edge count and the previous serial clock level
    always_ff @(posedge I_CLK) begin
        if (I_RST) begin
            rise_q <= 8'h00;
            sclk_q <= 1'b0;
        end else begin
            rise_q <= rise_d;
            sclk_q <= sclk;
        end
    end
    a_idle_release: assert property (cs_n |-> !dev_sdio_oe && !sep_out_oe)
        else $error("device drives a data pin while deselected");
    a_launch_on_fall: assert property ((dev_sdio_oe || sep_out_oe) && !cs_n && !$past(cs_n)
        && ($changed(dev_sdio_o) || $changed(sep_out_o)) |-> $fell(sclk))
        else $error("device output changed away from a falling serial edge");
    a_one_output_pin: assert property (!(dev_sdio_oe && sep_out_oe))
        else $error("both device output pins enabled");
    a_no_bus_fight: assert property (!(dev_sdio_oe && host_sdio_oe))
        else $error("host and device drive the shared pin together");
    a_quiet_instr: assert property (dev_sdio_oe |-> rise_q >= 8'h10)
        else $error("device drives the shared pin in the instruction phase");
    a_data_starts: assert property ($rose(dev_sdio_oe || sep_out_oe) |-> $fell(sclk) && rise_q == 8'h10)
        else $error("read data does not start at the fall after edge sixteen");
    a_host_yields: assert property ($fell(host_sdio_oe) && !cs_n |-> rise_q == 8'h10)
        else $error("host released the shared pin at the wrong edge");
    a_whole_bytes: assert property ($rose(cs_n) |-> rise_q >= 8'h18 && rise_q[2:0] == 3'h0)
        else $error("frame is not instruction plus whole bytes");
    a_select_held: assert property ($fell(cs_n) |-> !cs_n [*8])
        else $error("select bounced inside a frame");
    a_select_gap: assert property ($rose(cs_n) |=> cs_n [*7])
        else $error("select gap between frames too short");
    a_frame_on_fall: assert property ($fell(cs_n) |-> $fell(sclk))
        else $error("frame did not open on a falling serial edge");
endmodule // spi_cfg_chk

// ### sim/testbench.sv
// self-checking bench: host and device ends joined over the serial link
`timescale 1ns/1ps
`include "spi_cfg_defines.svh"
module testbench;
    localparam logic [31:0] RD = 32'h1 << `CTRL_READ;
    localparam logic [31:0] LSB = 32'h1 << `CTRL_LSB;
    localparam logic [31:0] FOUR = 32'h1 << `CTRL_FOUR;
    localparam logic [31:0] B2 = 32'h10;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] tword;
    logic tload;
    logic sreset;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int n_checks = 0;
    int loads = 0;
    int resets = 0;
    spi_cfg_if spi_cfg_if_inst ();
    spi_cfg_host spi_cfg_host_inst (.I_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .LINK(spi_cfg_if_inst));
    spi_cfg_device spi_cfg_device_inst (.LINK(spi_cfg_if_inst), .I_CLK(clk), .I_RST(rst),
        .O_TUNING_WORD(tword), .O_TUNING_LOAD(tload), .O_SOFT_RESET(sreset));
    spi_cfg_chk spi_cfg_chk_inst (.I_CLK(clk), .I_RST(rst), .sclk(spi_cfg_if_inst.sclk),
        .cs_n(spi_cfg_if_inst.cs_n), .host_sdio_oe(spi_cfg_if_inst.host_sdio_oe),
        .dev_sdio_o(spi_cfg_if_inst.dev_sdio_o), .dev_sdio_oe(spi_cfg_if_inst.dev_sdio_oe),
        .sep_out_o(spi_cfg_if_inst.sep_out_o), .sep_out_oe(spi_cfg_if_inst.sep_out_oe));
    // 40 MHz system clock
    always #12.5 clk = ~clk;
    // count one-cycle pulses from the device end
    always @(posedge clk) begin
        if (tload === 1'b1)
            loads++;
        if (sreset === 1'b1)
            resets++;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one apb transfer; read data and error taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
            @(posedge clk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one serial frame: program the host, start it, wait for done, clear it, fetch read data
    task automatic xfer(input logic [31:0] ctl, input logic [14:0] a, input logic [31:0] d);
        int n;
        // the host drops writes while busy, its warm-up after reset and the gap after a frame included
        n = 0;
        do begin
            apb(1'b0, {`H_STATUS, 2'b00}, 32'h0);
            n++;
        end while (rd[`ST_BUSY] !== 1'b0 && n < 2000);
        apb(1'b1, {`H_ADDR, 2'b00}, {17'h0, a});
        apb(1'b1, {`H_WDATA, 2'b00}, d);
        apb(1'b1, {`H_CTRL, 2'b00}, ctl | (32'h1 << `CTRL_GO));
        do begin
            apb(1'b0, {`H_STATUS, 2'b00}, 32'h0);
            n++;
        end while (rd[`ST_DONE] !== 1'b1 && n < 2000);
        // a frame that never finishes ends the run as a failure
        if (n >= 2000) begin
            num_errors++;
            final_report();
        end
        apb(1'b1, {`H_STATUS, 2'b00}, 32'h1 << `ST_DONE);
        apb(1'b0, {`H_RDATA, 2'b00}, 32'h0);
    endtask
    task automatic t_defaults();
        apb(1'b0, {`H_CTRL, 2'b00}, 32'h0);
        check(rd, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        xfer(RD, `ADDR_CFG, 32'h0);
        check(rd, {24'h0, `CFG_RESET});
        xfer(RD, 15'h0010, 32'h0);
        check(rd, 32'h0);
        $display("defaults done");
    endtask
    task automatic t_tuning();
        // default order is descending, so byte 0 lands at the start address
        xfer(B2, `ADDR_TW_HI, 32'h0000a53c);
        check({16'h0, tword}, 32'h0);
        xfer(RD | B2, `ADDR_TW_HI, 32'h0);
        check(rd, 32'h0000a53c);
        xfer(RD, `ADDR_TW_LO, 32'h0);
        check(rd, 32'h000000a5);
        xfer(32'h0, `ADDR_TW_LOAD, 32'h1);
        repeat (20) @(posedge clk);
        check({16'h0, tword}, 32'h00003ca5);
        check(32'(loads), 32'h1);
        $display("tuning done");
    endtask
    task automatic t_nibble();
        // low nibble would set every mirror and soft reset if it were not ignored
        xfer(32'h0, `ADDR_CFG, 32'h2f);
        xfer(RD, `ADDR_CFG, 32'h0);
        check(rd, 32'h24);
        check(32'(resets), 32'h0);
        xfer(B2, `ADDR_TW_LO, 32'h00005a66);
        xfer(RD, `ADDR_TW_HI, 32'h0);
        check(rd, 32'h5a);
        $display("nibble done");
    endtask
    task automatic t_order_wiring();
        xfer(32'h0, `ADDR_CFG, 32'h6f);
        xfer(RD | LSB, `ADDR_CFG, 32'h0);
        check(rd, 32'h66);
        xfer(RD | LSB | B2, `ADDR_TW_LO, 32'h0);
        check(rd, 32'h00005a66);
        // in lsb order only bits 3..0 count, so the soft mirror in bit 7 stays off
        xfer(LSB, `ADDR_CFG, 32'hfe);
        xfer(RD | LSB | FOUR, `ADDR_CFG, 32'h0);
        check(rd, 32'h7e);
        xfer(RD | LSB | FOUR, `ADDR_TW_LO, 32'h0);
        check(rd, 32'h66);
        $display("order and wiring done");
    endtask
    task automatic t_soft();
        xfer(LSB | FOUR, `ADDR_CFG, 32'h01);
        repeat (20) @(posedge clk);
        check(32'(resets), 32'h1);
        xfer(RD, `ADDR_CFG, 32'h0);
        check(rd, 32'h0);
        xfer(RD, `ADDR_TW_LO, 32'h0);
        check(rd, 32'h0);
        $display("soft reset done");
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        t_defaults();
        t_tuning();
        t_nibble();
        t_order_wiring();
        t_soft();
        final_report();
    end
    // watchdog: the whole run needs roughly a ninth of this span
    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        final_report();
    end
endmodule // testbench
